// *** src/iom_io_bank.sv ***
// Module: bank of user I/O cells with APB control and clock pad taps
//
// Function
// - Every pad links to exactly one cell by out data, in data, enable.
// - Side cells pick outgoing data from the upper or lower channel.
// - The per-cell enable drives the pad only while it is asserted.
// - Two global test controls disable all output paths and zero every array input whose input latch passes; the clock pad taps stay live.
// - The output latch holds while its gate is low, passes when high.
// - The input gate is always the complement of the output gate.
// - The input latch holds while its gate is high, passes when low.
// - The array output carries pad data through the input latch.
// - Reserved programming and probe pads act as plain I/O in user mode.
// - Two clock pads also feed the global clock networks.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps

module iom_io_bank #(
  parameter int unsigned NUM_CELLS = 8,
  parameter int unsigned ADDR_W    = 8,
  parameter logic [NUM_CELLS-1:0] SIDE_MASK = '1
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // APB slave
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Test mode disables from the test controller
  input  wire logic                  testInputDisable,
  input  wire logic                  testOutputDisable,
  // Routing array side
  input  wire iom_pkg::iom_user_t    userSide [NUM_CELLS],
  output logic [NUM_CELLS-1:0]       arrayInData,
  // Pad side
  input  wire logic [NUM_CELLS-1:0]  padInData,
  output logic [NUM_CELLS-1:0]       padOutData,
  output logic [NUM_CELLS-1:0]       padOutEn,
  // Global clock network sources
  output logic                       clockNetFirst,
  output logic                       clockNetSecond
);

  // ---------------------------------------------------------------------
  // Address decode helper
  // ---------------------------------------------------------------------
  function automatic logic regHit(input logic [ADDR_W-1:0] addr,
                                  input logic [7:0]        off);
    regHit = (addr == ADDR_W'(off));
  endfunction

  // ---------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------
  logic [1:0]           ctrl;
  logic [NUM_CELLS-1:0] srcSelLower;
  logic [NUM_CELLS-1:0] padOutLatch;

  // ---------------------------------------------------------------------
  // APB phase and decode
  // ---------------------------------------------------------------------
  wire logic setupPhase;
  wire logic accessPhase;
  wire logic hitCtrl;
  wire logic hitSrcSel;
  wire logic hitPadIn;
  wire logic hitArrayIn;
  wire logic hitDrive;
  wire logic hitPadOut;
  wire logic hitAny;
  wire logic writeCtrl;
  wire logic writeSrcSel;
  wire logic [31:0] readMux;

  // Zero wait: read data is captured in setup, ready in access
  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign hitCtrl     = regHit(paddr, iom_pkg::IOM_OFF_CTRL);
  assign hitSrcSel   = regHit(paddr, iom_pkg::IOM_OFF_SRC_SEL);
  assign hitPadIn    = regHit(paddr, iom_pkg::IOM_OFF_PAD_IN);
  assign hitArrayIn  = regHit(paddr, iom_pkg::IOM_OFF_ARRAY_IN);
  assign hitDrive    = regHit(paddr, iom_pkg::IOM_OFF_DRIVE);
  assign hitPadOut   = regHit(paddr, iom_pkg::IOM_OFF_PAD_OUT);
  assign hitAny      = hitCtrl | hitSrcSel | hitPadIn | hitArrayIn
                     | hitDrive | hitPadOut;
  // Only the low byte lane matters for the narrow control fields
  assign writeCtrl   = accessPhase & pwrite & hitCtrl & pstrb[0];
  assign writeSrcSel = accessPhase & pwrite & hitSrcSel;

  // Read selection; narrow fields sit low, upper bits read zero
  assign readMux =
      hitCtrl    ? 32'(ctrl)        :
      hitSrcSel  ? 32'(srcSelLower) :
      hitPadIn   ? 32'(padInData)   :
      hitArrayIn ? 32'(arrayInData) :
      hitDrive   ? 32'(padOutEn)    :
      hitPadOut  ? 32'(padOutLatch) :
                   iom_pkg::IOM_RDATA_RESET;

  assign pready = 1'b1;

  // ---------------------------------------------------------------------
  // Byte-lane merge for the source select register
  // ---------------------------------------------------------------------
  logic [31:0] srcSelWide;
  logic [31:0] next_srcSel;
  assign srcSelWide = 32'(srcSelLower);

  always_comb begin
    next_srcSel = srcSelWide;
    for (int b = 0; b < 4; b++) begin
      if (pstrb[b]) begin
        next_srcSel[b*8 +: 8] = pwdata[b*8 +: 8];
      end
    end
  end

  // ---------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl        <= iom_pkg::IOM_CTRL_RESET;
      srcSelLower <= NUM_CELLS'(iom_pkg::IOM_SRC_SEL_RESET);
    end else begin
      if (writeCtrl) begin
        ctrl <= pwdata[1:0];
      end
      if (writeSrcSel) begin
        srcSelLower <= next_srcSel[NUM_CELLS-1:0];
      end
    end
  end

  // ---------------------------------------------------------------------
  // Read data and error answer
  // ---------------------------------------------------------------------
  // Unmapped address answers with pslverr and zero data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata  <= iom_pkg::IOM_RDATA_RESET;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata  <= pwrite ? iom_pkg::IOM_RDATA_RESET : readMux;
      pslverr <= ~hitAny;
    end
  end

  // ---------------------------------------------------------------------
  // Global disables
  // ---------------------------------------------------------------------
  // Pins and register bits combine so either the test controller or
  // software can isolate every cell of the bank
  wire logic inDisableAll;
  wire logic outDisableAll;
  assign inDisableAll  = testInputDisable
                       | ctrl[iom_pkg::IOM_CTRL_IN_DIS_BIT];
  assign outDisableAll = testOutputDisable
                       | ctrl[iom_pkg::IOM_CTRL_OUT_DIS_BIT];

  // ---------------------------------------------------------------------
  // Cell array
  // ---------------------------------------------------------------------
  // Reserved programming, binning and probe pads are ordinary cells here
  iom_pkg::iom_pad_drv_t padDrv [NUM_CELLS];

  for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
    iom_io_cell #(
      .SIDE_CELL (SIDE_MASK[c])
    ) u_cell (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .user        (userSide[c]),
      .selLower    (srcSelLower[c]),
      .inDisable   (inDisableAll),
      .outDisable  (outDisableAll),
      .padInData   (padInData[c]),
      .padDrv      (padDrv[c]),
      .arrayInData (arrayInData[c])
    );
    assign padOutData[c]  = padDrv[c].padOutData;
    assign padOutEn[c]    = padDrv[c].padOutEn;
    assign padOutLatch[c] = padDrv[c].padOutData;
  end

  // ---------------------------------------------------------------------
  // Clock pad taps
  // ---------------------------------------------------------------------
  // Taken straight from the receiver, ahead of the input latch, so the
  // clock networks see no gate delay and no test-mode blocking
  assign clockNetFirst  = padInData[iom_pkg::IOM_CLK_PAD_FIRST];
  assign clockNetSecond = padInData[iom_pkg::IOM_CLK_PAD_SECOND];

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  for (genvar c = 0; c < NUM_CELLS; c++) begin : g_chk
    wire logic selData;
    assign selData = (SIDE_MASK[c] && srcSelLower[c])
                   ? userSide[c].userOutLower : userSide[c].userOutUpper;

    out_disable_a: assert property (
      outDisableAll |-> !padOutEn[c])
      else $error("driver enabled under output disable");

    drive_follow_a: assert property (
      !outDisableAll |-> padOutEn[c] == userSide[c].padEnable)
      else $error("driver enable does not follow cell enable");

    enable_low_a: assert property (
      !userSide[c].padEnable |-> !padOutEn[c])
      else $error("driver on without cell enable");

    out_pass_a: assert property (
      userSide[c].outLatchGate |-> padOutData[c] == selData)
      else $error("output latch not transparent");

    out_hold_a: assert property (
      !userSide[c].outLatchGate && !$past(userSide[c].outLatchGate)
      |-> $stable(padOutData[c]))
      else $error("output latch lost its value");

    in_block_a: assert property (
      inDisableAll && userSide[c].outLatchGate |-> !arrayInData[c])
      else $error("pad data reached array under input disable");

    in_pass_a: assert property (
      !inDisableAll && userSide[c].outLatchGate
      |-> arrayInData[c] == padInData[c])
      else $error("input latch not transparent");

    in_hold_a: assert property (
      !userSide[c].outLatchGate ##1 !userSide[c].outLatchGate
      |-> $stable(arrayInData[c]))
      else $error("input latch open while output gate low");

    capture_held_a: assert property (
      userSide[c].outLatchGate ##1 !userSide[c].outLatchGate
      |-> arrayInData[c] == $past(arrayInData[c]))
      else $error("input latch did not capture at gate edge");
  end

  clock_tap_a: assert property (
    clockNetFirst == padInData[iom_pkg::IOM_CLK_PAD_FIRST]
    && clockNetSecond == padInData[iom_pkg::IOM_CLK_PAD_SECOND])
    else $error("clock network source not the clock pad");

  ctrl_write_a: assert property (
    writeCtrl |=> ctrl == $past(pwdata[1:0]))
    else $error("control write not taken");

  unmapped_err_a: assert property (
    setupPhase && !hitAny ##1 accessPhase |-> pslverr && pready)
    else $error("unmapped access not refused");

  // ---------------------------------------------------------------------
  // Bus-side assertions
  // ---------------------------------------------------------------------
  // Registers move only on a decoded write, so a stray strobe cannot
  // flip a disable bit behind software's back
  ctrl_keep_a: assert property (
    !writeCtrl |=> $stable(ctrl))
    else $error("control changed without a write");

  src_keep_a: assert property (
    !writeSrcSel |=> $stable(srcSelLower))
    else $error("source select changed without a write");

  src_write_a: assert property (
    writeSrcSel && pstrb == 4'hf
    |=> srcSelLower == $past(pwdata[NUM_CELLS-1:0]))
    else $error("full source select write not taken");

  rdata_hold_a: assert property (
    !setupPhase |=> $stable(prdata) && $stable(pslverr))
    else $error("read answer moved outside a setup cycle");

  mapped_ok_a: assert property (
    setupPhase && hitAny |=> !pslverr)
    else $error("mapped access refused");

  unmapped_zero_a: assert property (
    setupPhase && !hitAny |=> prdata == iom_pkg::IOM_RDATA_RESET)
    else $error("unmapped read returned data");

  pad_in_read_a: assert property (
    setupPhase && !pwrite && hitPadIn
    |=> prdata[NUM_CELLS-1:0] == $past(padInData))
    else $error("pad input read does not show the receivers");

  drive_read_a: assert property (
    setupPhase && !pwrite && hitDrive
    |=> prdata[NUM_CELLS-1:0] == $past(padOutEn))
    else $error("driver enable read does not show the drivers");

endmodule // iom_io_bank

// *** src/iom_io_cell.sv ***
// Module: one I/O cell with gated output latch and complementary input latch
`timescale 1ns/1ps

module iom_io_cell #(
  parameter logic SIDE_CELL = 1'b1
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire iom_pkg::iom_user_t   user,
  input  wire logic                 selLower,
  input  wire logic                 inDisable,
  input  wire logic                 outDisable,
  input  wire logic                 padInData,
  output iom_pkg::iom_pad_drv_t     padDrv,
  output logic                      arrayInData
);

  // ---------------------------------------------------------------------
  // Source selection and latch gates
  // ---------------------------------------------------------------------
  logic heldOut;
  logic heldIn;
  wire  logic userOutData;
  wire  logic inLatchGate;
  wire  logic outValue;
  wire  logic inSource;

  // Top/bottom cells see one channel only, lower input ignored
  assign userOutData = (SIDE_CELL && selLower) ? user.userOutLower
                                               : user.userOutUpper;
  assign inLatchGate = ~user.outLatchGate;

  // Latches modelled as a hold flop plus bypass mux, so no real latch
  // is inferred; the held value is the one seen at the last edge open
  assign outValue = user.outLatchGate ? userOutData : heldOut;
  assign inSource = inDisable ? 1'b0 : padInData;

  // ---------------------------------------------------------------------
  // Hold registers
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      heldOut <= iom_pkg::IOM_LATCH_RESET;
      heldIn  <= iom_pkg::IOM_LATCH_RESET;
    end else begin
      heldOut <= outValue;
      heldIn  <= arrayInData;
    end
  end

  // ---------------------------------------------------------------------
  // Pad and array outputs
  // ---------------------------------------------------------------------
  // Global output disable overrides the per-cell enable
  assign padDrv.padOutData = outValue;
  assign padDrv.padOutEn   = user.padEnable & ~outDisable;
  assign arrayInData = inLatchGate ? heldIn : inSource;

endmodule // iom_io_cell

// *** src/iom_pkg.sv ***
// Package: constants, register map and carrier types of the I/O cell bank
package iom_pkg;

  // ---------------------------------------------------------------------
  // Register map (byte addresses, one aligned 32-bit word each)
  // ---------------------------------------------------------------------
  localparam logic [7:0] IOM_OFF_CTRL     = 8'h00; // Global test disables
  localparam logic [7:0] IOM_OFF_SRC_SEL  = 8'h04; // Side cell source pick
  localparam logic [7:0] IOM_OFF_PAD_IN   = 8'h08; // Raw pad receivers
  localparam logic [7:0] IOM_OFF_ARRAY_IN = 8'h0c; // Data into the array
  localparam logic [7:0] IOM_OFF_DRIVE    = 8'h10; // Live driver enables
  localparam logic [7:0] IOM_OFF_PAD_OUT  = 8'h14; // Output latch content

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned IOM_CTRL_IN_DIS_BIT  = 0;
  localparam int unsigned IOM_CTRL_OUT_DIS_BIT = 1;
  localparam logic [1:0]  IOM_CTRL_RESET       = 2'h0;
  localparam logic [31:0] IOM_SRC_SEL_RESET    = 32'h0000_0000;
  localparam logic [31:0] IOM_RDATA_RESET      = 32'h0000_0000;
  localparam logic        IOM_LATCH_RESET      = 1'h0;

  // ---------------------------------------------------------------------
  // Clock pad positions inside the bank
  // ---------------------------------------------------------------------
  localparam int unsigned IOM_CLK_PAD_FIRST  = 0;
  localparam int unsigned IOM_CLK_PAD_SECOND = 1;

  // ---------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------
  // Array-facing controls of one cell
  typedef struct packed {
    logic userOutUpper;  // Outgoing data from the channel above
    logic userOutLower;  // Outgoing data from the channel below
    logic padEnable;     // Per-cell driver enable
    logic outLatchGate;  // High: output latch transparent
  } iom_user_t;

  // Pad driver side of one cell
  typedef struct packed {
    logic padOutData;    // Data toward the pad driver
    logic padOutEn;      // High while the cell drives the pad
  } iom_pad_drv_t;

endpackage

// *** verif/iom_user_model.sv ***
// Partner model: user logic in the array feeding the cells' array side
`timescale 1ns/1ps

module iom_user_model #(
  parameter int unsigned NUM_CELLS = 8
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic [NUM_CELLS-1:0] dataVal,
  input  wire logic [NUM_CELLS-1:0] enVal,
  input  wire logic                 gateVal,
  input  wire logic                 ffMode,
  output iom_pkg::iom_user_t        userSide [NUM_CELLS]
);
  logic                 phase;
  logic [NUM_CELLS-1:0] stageOne;

  // First stage opens while the cell gate is low, so the pair is a flop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase    <= 1'b0;
      stageOne <= '0;
    end else begin
      phase <= ffMode & ~phase;
      if (!phase) begin
        stageOne <= dataVal;
      end
    end
  end

  // Lower channel carries the inverse, so a wrong source pick shows
  for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
    wire logic src = ffMode ? stageOne[c] : dataVal[c];
    wire logic gate = ffMode ? phase : gateVal;
    assign userSide[c] = {src, ~src, enVal[c], gate};
  end

endmodule // iom_user_model

// *** verif/testbench.sv ***
// Testbench: register map and cell behaviour of the I/O cell bank
`timescale 1ns/1ps

module testbench;
  logic               sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr, arrayIn, padIn, padOut, padEn, dataVal, enVal;
  logic [31:0]        pwdata, prdata;
  logic [3:0]         pstrb;
  logic               tInDis, tOutDis, clkNet1, clkNet2, gateVal, ffMode;
  iom_pkg::iom_user_t userSide [8];
  int                 err_total = 0;
  int                 checks = 0;

  // Top and bottom cells in the upper half ignore the source pick
  iom_io_bank #(.NUM_CELLS(8), .ADDR_W(8), .SIDE_MASK(8'h0f)) dut (
    .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .testInputDisable(tInDis), .testOutputDisable(tOutDis),
    .userSide(userSide), .arrayInData(arrayIn), .padInData(padIn),
    .padOutData(padOut), .padOutEn(padEn), .clockNetFirst(clkNet1),
    .clockNetSecond(clkNet2));

  iom_user_model #(.NUM_CELLS(8)) user_logic (
    .sys_clk(sys_clk), .rst(rst), .dataVal(dataVal), .enVal(enVal),
    .gateVal(gateVal), .ffMode(ffMode), .userSide(userSide));

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high at an edge
  task automatic apb(input logic [7:0] a, input logic wr,
                     input logic [31:0] wd, input logic [3:0] st,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge sys_clk);
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= wd;
    pstrb   <= st;
    psel    <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) err_total++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] st);
    logic [31:0] rd;
    logic        err;
    apb(a, 1'b1, d, st, rd, err);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                       input logic experr);
    logic [31:0] rd;
    logic        err;
    apb(a, 1'b0, 32'h0, 4'h0, rd, err);
    check(rd, exp);
    check(32'(err), 32'(experr));
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_regs();
    rdchk(iom_pkg::IOM_OFF_CTRL, 32'h0, 1'b0);
    rdchk(iom_pkg::IOM_OFF_SRC_SEL, 32'h0, 1'b0);
    wr(iom_pkg::IOM_OFF_CTRL, 32'hffff_ffff, 4'he);
    rdchk(iom_pkg::IOM_OFF_CTRL, 32'h0, 1'b0);
    wr(iom_pkg::IOM_OFF_SRC_SEL, 32'hffff_ffff, 4'hf);
    rdchk(iom_pkg::IOM_OFF_SRC_SEL, 32'hff, 1'b0);
    wr(iom_pkg::IOM_OFF_PAD_IN, 32'hffff_ffff, 4'hf);
    rdchk(iom_pkg::IOM_OFF_PAD_IN, 32'h0, 1'b0);
    rdchk(8'h18, 32'h0, 1'b1);
  endtask

  // Source pick only in side cells, lower channel is inverted data
  task automatic t_src();
    @(posedge sys_clk);
    gateVal <= 1'b1;
    dataVal <= 8'ha5;
    #1;
    check(32'(padOut), 32'haa);
    wr(iom_pkg::IOM_OFF_SRC_SEL, 32'h0, 4'hf);
    #1;
    check(32'(padOut), 32'ha5);
  endtask

  // Open gate passes both paths, closed gate holds both latches
  task automatic t_cell();
    @(posedge sys_clk);
    dataVal <= 8'ha5;
    enVal   <= 8'h0f;
    padIn   <= 8'h3c;
    #1;
    check(32'(padEn), 32'h0f);
    check(32'(arrayIn), 32'h3c);
    @(posedge sys_clk);
    gateVal <= 1'b0;
    dataVal <= 8'h5a;
    padIn   <= 8'hc2;
    #1;
    check(32'(padOut), 32'ha5);
    check(32'(arrayIn), 32'h3c);
    check(32'({clkNet2, clkNet1}), 32'h2);
    rdchk(iom_pkg::IOM_OFF_PAD_OUT, 32'ha5, 1'b0);
    rdchk(iom_pkg::IOM_OFF_DRIVE, 32'h0f, 1'b0);
    rdchk(iom_pkg::IOM_OFF_ARRAY_IN, 32'h3c, 1'b0);
    rdchk(iom_pkg::IOM_OFF_PAD_IN, 32'hc2, 1'b0);
  endtask

  // Every mix of register and test-pin disables
  task automatic t_dis();
    @(posedge sys_clk);
    gateVal <= 1'b1;
    padIn   <= 8'h3d;
    for (int i = 0; i < 16; i++) begin
      wr(iom_pkg::IOM_OFF_CTRL, 32'(i[1:0]), 4'hf);
      @(posedge sys_clk);
      tInDis  <= i[2];
      tOutDis <= i[3];
      #1;
      check(32'(padEn), (i[1] | i[3]) ? 32'h0 : 32'h0f);
      check(32'(arrayIn), (i[0] | i[2]) ? 32'h0 : 32'h3d);
      check(32'(clkNet1), 32'h1);
    end
  endtask

  // Array flop built from an upstream latch and the output latch
  task automatic t_ff();
    @(posedge sys_clk);
    ffMode  <= 1'b1;
    dataVal <= 8'h96;
    repeat (6) @(posedge sys_clk);
    #1;
    check(32'(padOut), 32'h96);
    @(posedge sys_clk);
    dataVal <= 8'h69;
    repeat (6) @(posedge sys_clk);
    #1;
    check(32'(padOut), 32'h69);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Clock, main sequence and watchdog
  // ---------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, pwdata, pstrb, paddr} = '0;
    {tInDis, tOutDis, gateVal, ffMode, dataVal, enVal, padIn} = '0;
    repeat (8) @(posedge sys_clk);
    // User mode only: special pads are plain
    rst <= 1'b0;
    t_regs();
    t_src();
    t_cell();
    t_dis();
    t_ff();
    report_and_stop();
  end

  // A hang costs a mismatch; the whole run needs well under two microseconds
  initial begin
    #50us;
    err_total++;
    report_and_stop();
  end

endmodule // testbench
